/* File: design/pct_cycle_timing.sv */
// Card cycle timing generator: setup, strobe and hold sequencing
`timescale 1ns/100ps
`default_nettype none
module pct_cycle_timing (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request side
  input wire logic cycleStart,
  input wire logic cycleIsMem,
  input wire logic cycleIsWrite,
  input wire logic cycleIs16,
  input wire logic cycleAttr,
  input wire logic [25:0] cycleAddr,
  input wire logic [1:0] waitStateSelect,
  input wire logic zeroWaitSelect,
  output logic cycleBusy,
  output logic cycleDone,
  // Card side
  output logic [25:0] cardAddress,
  output logic cardAddrValid,
  output logic cardAttrSelect,
  output logic memReadStrobe_n,
  output logic memWriteStrobe_n,
  output logic ioReadStrobe_n,
  output logic ioWriteStrobe_n,
  input wire logic cardWait_n,
  input wire logic batteryDetectTwo,
  output logic speakerOutput
);
  // Reset release through two flops
  logic rstSync1_r, rstSync_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstSync1_r <= 1'b1;
      rstSync_r <= rstSync1_r;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  logic waitMeta_r, waitSync_r, bvdMeta_r, bvdSync_r;
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      waitMeta_r <= 1'b1;
      waitSync_r <= 1'b1;
      bvdMeta_r <= 1'b1;
      bvdSync_r <= 1'b1;
    end
    else
    begin
      waitMeta_r <= cardWait_n;
      waitSync_r <= waitMeta_r;
      bvdMeta_r <= batteryDetectTwo;
      bvdSync_r <= bvdMeta_r;
    end
  end

  // Speaker follows battery detect two, registered
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      speakerOutput <= 1'b1;
    else
      speakerOutput <= bvdSync_r;
  end

  // Interval selection from the request's wait settings
  logic [4:0] setupCnt, activeCnt, holdCnt;
  always_comb
  begin
    if (!cycleIsMem)
      setupCnt = pct_pkg::SETUP_IO;
    else if (waitStateSelect[1])
      setupCnt = pct_pkg::SETUP_MEM_SLOW;
    else
      setupCnt = pct_pkg::SETUP_MEM_FAST;
    if (!cycleIsMem)
      holdCnt = pct_pkg::HOLD_IO;
    else if (waitStateSelect[1])
      holdCnt = pct_pkg::HOLD_MEM_SLOW;
    else
      holdCnt = pct_pkg::HOLD_MEM_FAST;
    if (!cycleIs16)
    begin
      // I/O uses bit 0 only; memory any nonzero code
      if ((cycleIsMem ? |waitStateSelect : waitStateSelect[0]))
        activeCnt = pct_pkg::ACT8_WAIT;
      else if (zeroWaitSelect)
        activeCnt = pct_pkg::ACT8_ZERO;
      else
        activeCnt = pct_pkg::ACT8_BASE;
    end
    else if (!cycleIsMem)
      // Zero-wait is ignored for 16-bit I/O
      activeCnt = waitStateSelect[0] ? pct_pkg::ACT16IO_WAIT
                                     : pct_pkg::ACT16IO_BASE;
    else
    begin
      unique case (waitStateSelect)
        2'h0: activeCnt = zeroWaitSelect ? pct_pkg::ACT16M_ZERO
                                         : pct_pkg::ACT16M_WS0;
        2'h1: activeCnt = pct_pkg::ACT16M_WS1;
        2'h2: activeCnt = pct_pkg::ACT16M_WS2;
        2'h3: activeCnt = pct_pkg::ACT16M_WS3;
      endcase
    end
  end

  // Phase machine counting whole clocks per interval
  pct_pkg::pct_phase_e phase_r;
  logic [4:0] count_r, holdLoad_r, activeLoad_r;
  logic isMem_r, isWrite_r;
  logic lastCount;
  assign lastCount = (count_r == 5'h01);
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      phase_r <= pct_pkg::PH_IDLE;
      count_r <= 5'h00;
      holdLoad_r <= 5'h00;
      activeLoad_r <= 5'h00;
      isMem_r <= 1'b0;
      isWrite_r <= 1'b0;
    end
    else
    begin
      unique case (phase_r)
        pct_pkg::PH_IDLE:
          if (cycleStart)
          begin
            phase_r <= pct_pkg::PH_SETUP;
            // Setup padded by two clocks so address leads strobe
            count_r <= 5'(setupCnt + pct_pkg::SETUP_EXTRA);
            activeLoad_r <= activeCnt;
            holdLoad_r <= 5'(holdCnt + pct_pkg::HOLD_EXTRA);
            isMem_r <= cycleIsMem;
            isWrite_r <= cycleIsWrite;
          end
        pct_pkg::PH_SETUP:
          if (lastCount)
          begin
            phase_r <= pct_pkg::PH_ACTIVE;
            count_r <= activeLoad_r;
          end
          else
            count_r <= count_r - 5'h01;
        pct_pkg::PH_ACTIVE:
          // Card wait freezes the count at its last clock
          if (lastCount && waitSync_r)
          begin
            phase_r <= pct_pkg::PH_HOLD;
            count_r <= holdLoad_r;
          end
          else if (!lastCount)
            count_r <= count_r - 5'h01;
        pct_pkg::PH_HOLD:
          if (lastCount)
            phase_r <= pct_pkg::PH_IDLE;
          else
            count_r <= count_r - 5'h01;
      endcase
    end
  end

  // Address and attribute latched for the whole cycle
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      cardAddress <= 26'h0000000;
      cardAttrSelect <= 1'b0;
    end
    else if (phase_r == pct_pkg::PH_IDLE && cycleStart)
    begin
      cardAddress <= cycleAddr;
      cardAttrSelect <= cycleAttr;
    end
  end

  // Strobes and status decoded from the phase
  logic strobeOn;
  assign strobeOn = (phase_r == pct_pkg::PH_ACTIVE);
  assign memReadStrobe_n = !(strobeOn && isMem_r && !isWrite_r);
  assign memWriteStrobe_n = !(strobeOn && isMem_r && isWrite_r);
  assign ioReadStrobe_n = !(strobeOn && !isMem_r && !isWrite_r);
  assign ioWriteStrobe_n = !(strobeOn && !isMem_r && isWrite_r);
  assign cardAddrValid = (phase_r != pct_pkg::PH_IDLE);
  assign cycleBusy = (phase_r != pct_pkg::PH_IDLE);
  assign cycleDone = (phase_r == pct_pkg::PH_HOLD) && lastCount;

  // Checks on the sequence
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstSync_r);
  // Request settings kept for the checks; the datapath does not keep them
  logic chkIs16_r, chkZw_r;
  logic [1:0] chkWs_r;
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      chkIs16_r <= 1'b0;
      chkZw_r <= 1'b0;
      chkWs_r <= 2'h0;
    end
    else if (phase_r == pct_pkg::PH_IDLE && cycleStart)
    begin
      chkIs16_r <= cycleIs16;
      chkZw_r <= zeroWaitSelect;
      chkWs_r <= waitStateSelect;
    end
  end
  // Setup clocks of this cycle, still standing on the first strobe clock
  logic [4:0] runLen_r;
  always_ff @(posedge core_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      runLen_r <= 5'h00;
    else if (phase_r == pct_pkg::PH_SETUP)
      runLen_r <= runLen_r + 5'h01;
    else
      runLen_r <= 5'h00;
  end
  setup_io_len_a: assert property (phase_r == pct_pkg::PH_IDLE
    && cycleStart && !cycleIsMem |=> phase_r == pct_pkg::PH_SETUP [*5]
    ##1 phase_r == pct_pkg::PH_ACTIVE) else $error("io setup length");
  setup_mem_a: assert property (phase_r == pct_pkg::PH_IDLE
    && cycleStart && cycleIsMem && !waitStateSelect[1]
    |=> pct_pkg::PH_SETUP == phase_r [*4]
    ##1 phase_r == pct_pkg::PH_ACTIVE) else $error("mem setup length");
  setup_total_a: assert property ($rose(strobeOn)
    |-> runLen_r == 5'((isMem_r ? (chkWs_r[1] ? pct_pkg::SETUP_MEM_SLOW
    : pct_pkg::SETUP_MEM_FAST) : pct_pkg::SETUP_IO) + pct_pkg::SETUP_EXTRA))
    else $error("setup length");
  act8_zero_a: assert property ($rose(strobeOn) && !chkIs16_r
    && chkWs_r == 2'h0 && chkZw_r |-> strobeOn [*7]
    ##1 (!strobeOn || !$past(waitSync_r)))
    else $error("8-bit zero-wait strobe length");
  wait_stretch_a: assert property (strobeOn && count_r == 5'h01
    && !waitSync_r |=> strobeOn) else $error("strobe ended under wait");
  act16m_load_a: assert property (isMem_r && chkIs16_r
    && phase_r == pct_pkg::PH_SETUP && lastCount |=> count_r == (chkWs_r[1]
    ? (chkWs_r[0] ? pct_pkg::ACT16M_WS3 : pct_pkg::ACT16M_WS2)
    : (chkWs_r[0] ? pct_pkg::ACT16M_WS1 : (chkZw_r ? pct_pkg::ACT16M_ZERO
    : pct_pkg::ACT16M_WS0)))) else $error("active count load");
  hold_len_a: assert property (!isMem_r
    && $rose(phase_r == pct_pkg::PH_HOLD) |-> cardAddrValid [*3]
    ##1 !cardAddrValid) else $error("io hold length");
  io16_len_a: assert property ($rose(strobeOn) && count_r == 5'h07
    |-> strobeOn [*7]) else $error("active cut short");
  strobe_one_a: assert property ($onehot0({~memReadStrobe_n,
    ~memWriteStrobe_n, ~ioReadStrobe_n, ~ioWriteStrobe_n}))
    else $error("two strobes at once");
  speaker_a: assert property ($rose(bvdSync_r) |=> speakerOutput)
    else $error("speaker lag");
  cov_mem_c: cover property (!memReadStrobe_n ##1 memReadStrobe_n);
  cov_io_c: cover property (!ioWriteStrobe_n ##1 ioWriteStrobe_n);
  cov_wait_c: cover property (strobeOn && !waitSync_r);
  cov_done_c: cover property (cycleDone);
endmodule
`default_nettype wire

/* File: design/pct_pkg.sv */
// Constants for the card cycle timing generator
package pct_pkg;
  // Address setup counts in clocks
  localparam logic [4:0] SETUP_IO = 5'h03;
  localparam logic [4:0] SETUP_MEM_FAST = 5'h02;
  localparam logic [4:0] SETUP_MEM_SLOW = 5'h04;
  // Extra setup clocks before the strobe
  localparam logic [4:0] SETUP_EXTRA = 5'h02;
  // Command active counts, 8-bit cycles
  localparam logic [4:0] ACT8_BASE = 5'h13;
  localparam logic [4:0] ACT8_WAIT = 5'h17;
  localparam logic [4:0] ACT8_ZERO = 5'h07;
  // Command active counts, 16-bit memory cycles
  localparam logic [4:0] ACT16M_WS0 = 5'h09;
  localparam logic [4:0] ACT16M_WS1 = 5'h0d;
  localparam logic [4:0] ACT16M_WS2 = 5'h11;
  localparam logic [4:0] ACT16M_WS3 = 5'h17;
  localparam logic [4:0] ACT16M_ZERO = 5'h05;
  // Command active counts, 16-bit I/O cycles
  localparam logic [4:0] ACT16IO_BASE = 5'h07;
  localparam logic [4:0] ACT16IO_WAIT = 5'h0b;
  // Address hold counts in clocks
  localparam logic [4:0] HOLD_IO = 5'h02;
  localparam logic [4:0] HOLD_MEM_FAST = 5'h02;
  localparam logic [4:0] HOLD_MEM_SLOW = 5'h03;
  // Extra hold clocks after the strobe
  localparam logic [4:0] HOLD_EXTRA = 5'h01;
  // Cycle phases
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_HOLD} pct_phase_e;
endpackage

/* File: sim/pct_card_model.sv */
// Behavioural card model: wait line and battery-detect line
`timescale 1ns/100ps
`default_nettype none
module pct_card_model (
  // Clock
  input wire logic core_clk,
  // Strobes from the controller
  input wire logic memReadStrobe_n,
  input wire logic memWriteStrobe_n,
  input wire logic ioReadStrobe_n,
  input wire logic ioWriteStrobe_n,
  // Bench commands
  input wire logic [5:0] waitSpan,
  input wire logic batteryLevel,
  // Card lines
  output logic cardWait_n,
  output logic batteryDetectTwo
);
  logic anyLow;
  logic [5:0] lowCnt_r;
  assign anyLow = !(memReadStrobe_n && memWriteStrobe_n && ioReadStrobe_n &&
    ioWriteStrobe_n);
  // Strobe-low clocks seen in this cycle
  always_ff @(posedge core_clk)
    lowCnt_r <= anyLow ? lowCnt_r + 6'h01 : 6'h00;
  // Pulled up when released; a zero span is a prompt card
  assign cardWait_n = !(anyLow && lowCnt_r < waitSpan);
  assign batteryDetectTwo = batteryLevel;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the card cycle timing generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk, rst_n, cycleStart, cycleIsMem, cycleIsWrite, cycleIs16;
  logic cycleAttr, zeroWaitSelect, cycleBusy, cycleDone, cardAddrValid;
  logic cardAttrSelect, memReadStrobe_n, memWriteStrobe_n, ioReadStrobe_n;
  logic ioWriteStrobe_n, cardWait_n, batteryDetectTwo, speakerOutput;
  logic batteryLevel;
  logic [1:0] waitStateSelect;
  logic [25:0] cycleAddr, cardAddress;
  logic [5:0] waitSpan;
  logic [31:0] lfsr;
  int errors, samples_checked;
  pct_cycle_timing pct_cycle_timing_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cycleStart(cycleStart), .cycleIsMem(cycleIsMem),
    .cycleIsWrite(cycleIsWrite), .cycleIs16(cycleIs16),
    .cycleAttr(cycleAttr), .cycleAddr(cycleAddr),
    .waitStateSelect(waitStateSelect), .zeroWaitSelect(zeroWaitSelect),
    .cycleBusy(cycleBusy), .cycleDone(cycleDone), .cardAddress(cardAddress),
    .cardAddrValid(cardAddrValid), .cardAttrSelect(cardAttrSelect),
    .memReadStrobe_n(memReadStrobe_n), .memWriteStrobe_n(memWriteStrobe_n),
    .ioReadStrobe_n(ioReadStrobe_n), .ioWriteStrobe_n(ioWriteStrobe_n),
    .cardWait_n(cardWait_n), .batteryDetectTwo(batteryDetectTwo),
    .speakerOutput(speakerOutput));
  pct_card_model pct_card_model_inst (.core_clk(core_clk),
    .memReadStrobe_n(memReadStrobe_n), .memWriteStrobe_n(memWriteStrobe_n),
    .ioReadStrobe_n(ioReadStrobe_n), .ioWriteStrobe_n(ioWriteStrobe_n),
    .waitSpan(waitSpan), .batteryLevel(batteryLevel),
    .cardWait_n(cardWait_n), .batteryDetectTwo(batteryDetectTwo));
  // Free-running 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Pseudo-random source, fixed seed so runs repeat
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Expected strobe-low clocks without card wait
  function automatic int actLen(logic m, logic s, logic [1:0] ws, logic zw);
    if (!s)
      return (m ? ws != 2'h0 : ws[0]) ? 23 : (zw ? 7 : 19);
    if (!m)
      return ws[0] ? 11 : 7;
    case (ws)
      2'h0: return zw ? 5 : 9;
      2'h1: return 13;
      2'h2: return 17;
      default: return 23;
    endcase
  endfunction
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One card cycle; ex adds card wait, poke keeps start high for three more clocks
  task automatic run(input logic m, w, s, a, input logic [1:0] ws,
    input logic zw, input int ex, input logic poke);
    int su, ac, ho, nd, el;
    logic [25:0] ad;
    logic [3:0] sv, es;
    ad = 26'(rnd());
    el = actLen(m, s, ws, zw);
    // Four-bit pattern: only the strobe of this cycle's kind is low
    es = ~(4'h1 << {m, ~w});
    su = 0;
    ac = 0;
    ho = 0;
    nd = 0;
    @(posedge core_clk);
    cycleStart <= 1'b1;
    cycleIsMem <= m;
    cycleIsWrite <= w;
    cycleIs16 <= s;
    cycleAttr <= a;
    cycleAddr <= ad;
    waitStateSelect <= ws;
    zeroWaitSelect <= zw;
    waitSpan <= (ex > 0) ? 6'(el + ex) : 6'h00;
    batteryLevel <= lfsr[3];
    for (int t = 0; t < 200; t++)
    begin
      @(posedge core_clk);
      cycleStart <= poke && t < 3;
      #1;
      if (!cycleBusy)
        break;
      sv = {memReadStrobe_n, memWriteStrobe_n, ioReadStrobe_n, ioWriteStrobe_n};
      chk("address", ad, cardAddress);
      chk("attr valid", {a, 1'b1}, {cardAttrSelect, cardAddrValid});
      nd = nd * 2 + cycleDone;
      if (sv != 4'hf)
      begin
        chk("strobe", es, sv);
        ac++;
      end
      else if (ac == 0)
        su++;
      else
        ho++;
    end
    chk("setup", (m ? (ws[1] ? 4 : 2) : 3) + 2, su);
    if (ex == 0)
      chk("active", el, ac);
    else
      chk("stretch", 1, ac >= el + ex && ac <= el + ex + 3);
    chk("hold", ((m && ws[1]) ? 3 : 2) + 1, ho);
    chk("done", 1, nd);
    chk("speaker", batteryLevel, speakerOutput);
  endtask
  task automatic end_of_test();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence: reset, every setting corner, then random traffic
  initial
  begin
    lfsr = 32'he29c;
    errors = 0;
    samples_checked = 0;
    {rst_n, cycleStart, cycleIsMem, cycleIsWrite, cycleIs16} = 5'h00;
    {cycleAttr, waitStateSelect, zeroWaitSelect, batteryLevel} = 5'h00;
    cycleAddr = 26'h0;
    waitSpan = 6'h00;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("reset", 32'h1f, {cycleBusy, cycleDone, cardAddrValid, memReadStrobe_n,
      memWriteStrobe_n, ioReadStrobe_n, ioWriteStrobe_n, speakerOutput});
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 32; i++)
    begin
      void'(rnd());
      run(i[4], lfsr[0], i[3], lfsr[1], i[2:1], i[0], 0, i[1:0] == 2'h3);
    end
    for (int i = 0; i < 24; i++)
    begin
      void'(rnd());
      run(lfsr[0], lfsr[1], lfsr[2], lfsr[3], lfsr[5:4], lfsr[6],
        lfsr[7] ? int'(lfsr[9:8]) + 1 : 0, lfsr[10]);
    end
    end_of_test();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
